/* File: host_command_port.sv */
// host command port: passive 8-bit parallel port plus serial slave with busy pacing
// assumes only one of the two host ports is wired in a given system
`timescale 1ns/100ps
`include "host_port_defines.svh"
module host_command_port #(
  parameter host_port_pkg::byte_t MISO_IRQ_CMD = `MISO_IRQ_CMD_DEF
) (
  // system
  input wire logic                  clk,
  input wire logic                  nrst,
  // parallel port pins
  input wire logic                  parallel_select_n,
  input wire logic                  port_select,
  input wire logic                  rd_n,
  input wire logic                  wr_n,
  input wire host_port_pkg::byte_t  pdata_in,
  output host_port_pkg::byte_t      pdata_out,
  output logic                      pdata_oe,
  // serial pins
  input wire logic                  sck,
  input wire logic                  serial_select_n,
  input wire logic                  mosi,
  output logic                      miso,
  output logic                      miso_oe,
  output logic                      serial_busy_out,
  // interrupt pin
  output logic                      int_n,
  // core side
  output logic                      cmd_valid,
  output host_port_pkg::byte_t      cmd_code,
  output logic                      cmd_from_spi,
  output logic                      data_valid,
  output host_port_pkg::byte_t      data_byte,
  output logic                      rd_take,
  input wire host_port_pkg::byte_t  rd_data,
  input wire logic                  irq_req
);
  import host_port_pkg::*;

  localparam int GAP = `BYTE_GAP_CYCLES;

  spi_link_if l ();

  spi_link spi_link_i (
    .sck             (sck),
    .nrst            (nrst),
    .serial_select_n (serial_select_n),
    .mosi            (mosi),
    .l               (l)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] cs_sy_q;
  logic [1:0] rd_sy_q;
  logic [1:0] wr_sy_q;
  logic [1:0] ps_sy_q;
  byte_t      d_sy1_q;
  byte_t      d_sy2_q;
  logic [2:0] tg_sy_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cs_sy_q <= 2'h3;
      rd_sy_q <= 2'h3;
      wr_sy_q <= 2'h3;
      ps_sy_q <= 2'h0;
      d_sy1_q <= 8'h00;
      d_sy2_q <= 8'h00;
      tg_sy_q <= 3'h0;
    end else begin
      cs_sy_q <= {cs_sy_q[0], parallel_select_n};
      rd_sy_q <= {rd_sy_q[0], rd_n};
      wr_sy_q <= {wr_sy_q[0], wr_n};
      ps_sy_q <= {ps_sy_q[0], port_select};
      d_sy1_q <= pdata_in;
      d_sy2_q <= d_sy1_q;
      tg_sy_q <= {tg_sy_q[1:0], l.rx_tgl};
    end
  end

  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic ps_s;
  logic wr_act;
  logic rd_act;
  logic spi_evt;

  assign cs_s    = cs_sy_q[1];
  assign rd_s    = rd_sy_q[1];
  assign wr_s    = wr_sy_q[1];
  assign ps_s    = ps_sy_q[1];
  // a low write wins over a low read, which lets r/w-style hosts tie read low
  assign wr_act  = !cs_s && !wr_s;
  assign rd_act  = !cs_s && !rd_s && wr_s;
  assign spi_evt = tg_sy_q[2] ^ tg_sy_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // parallel access sequencing

  par_state_t state_q;
  byte_t      hold_d_q;
  logic       hold_p_q;
  logic       par_emit;
  logic       par_take;

  // byte is taken at the trailing edge of the strobe, when the bus has settled
  assign par_emit = (state_q == PAR_WRITE) && !wr_act;
  assign par_take = (state_q == PAR_READ) && !rd_act && (hold_p_q == `PORT_DATA);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= PAR_IDLE;
    end else begin
      case (state_q)
        PAR_IDLE: begin
          if (wr_act) begin
            state_q <= PAR_WRITE;
          end else if (rd_act) begin
            state_q <= PAR_READ;
          end
        end
        PAR_WRITE: begin
          if (!wr_act) begin
            state_q <= PAR_IDLE;
          end
        end
        PAR_READ: begin
          if (!rd_act) begin
            state_q <= PAR_IDLE;
          end
        end
        default: begin
          state_q <= PAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_d_q <= 8'h00;
      hold_p_q <= `PORT_DATA;
    end else if (wr_act || rd_act) begin
      hold_d_q <= d_sy2_q;
      hold_p_q <= ps_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel read drive

  byte_t status_b;
  logic  int_n_q;
  logic  busy_q;

  always_comb begin
    status_b                  = 8'h00;
    status_b[`STAT_IRQ_N_BIT] = int_n_q;
    status_b[`STAT_BUSY_BIT]  = busy_q;
  end

  // enable follows the synchronised strobe, so it trails the pins by ~3 clocks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pdata_oe  <= 1'b0;
      pdata_out <= 8'h00;
    end else begin
      pdata_oe <= rd_act;
      if (rd_act) begin
        pdata_out <= (ps_s == `PORT_CMD) ? status_b : rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte delivery to the core; parallel has priority, one port is used per system

  logic spi_cmd;
  logic spi_dat;

  assign spi_cmd = spi_evt && l.rx_cmd && !par_emit;
  assign spi_dat = spi_evt && !l.rx_cmd && !par_emit;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_valid    <= 1'b0;
      cmd_code     <= 8'h00;
      cmd_from_spi <= 1'b0;
      data_valid   <= 1'b0;
      data_byte    <= 8'h00;
    end else begin
      cmd_valid  <= 1'b0;
      data_valid <= 1'b0;
      if (par_emit && hold_p_q == `PORT_CMD) begin
        cmd_valid    <= 1'b1;
        cmd_code     <= hold_d_q;
        cmd_from_spi <= 1'b0;
      end else if (par_emit) begin
        data_valid <= 1'b1;
        data_byte  <= hold_d_q;
      end else if (spi_cmd) begin
        cmd_valid    <= 1'b1;
        cmd_code     <= l.rx_byte;
        cmd_from_spi <= 1'b1;
      end else if (spi_dat) begin
        data_valid <= 1'b1;
        data_byte  <= l.rx_byte;
      end
    end
  end

  // every serial data byte also consumes one output byte, read or write alike
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_take <= 1'b0;
    end else begin
      rd_take <= par_take || spi_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial busy pacing and output word

  logic [`GAP_CNT_W-1:0] gap_q;
  byte_t                 tx_word_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_q <= `BUSY_RESET;
      gap_q  <= '0;
    end else if (spi_evt) begin
      busy_q <= 1'b1;
      gap_q  <= `GAP_CNT_W'(GAP - 1);
    end else if (gap_q != '0) begin
      gap_q <= gap_q - `GAP_CNT_W'(1);
    end else begin
      busy_q <= 1'b0;
    end
  end

  assign serial_busy_out = busy_q;

  // the word only moves while idle, so sck-side reads it as a still value
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_word_q <= 8'h00;
    end else if (!busy_q && !spi_evt) begin
      tx_word_q <= rd_data;
    end
  end

  assign l.tx_word = tx_word_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin and miso reuse

  logic irq_mode_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      int_n_q <= `INT_N_RESET;
    end else begin
      int_n_q <= !irq_req;
    end
  end

  assign int_n = int_n_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_mode_q <= `IRQ_MODE_RESET;
    end else if ((par_emit && hold_p_q == `PORT_CMD && hold_d_q == MISO_IRQ_CMD) ||
                 (spi_cmd && l.rx_byte == MISO_IRQ_CMD)) begin
      irq_mode_q <= 1'b1;
    end
  end

  // select is used raw here: the pin must swap within the deselect edge itself
  assign miso    = serial_select_n ? int_n_q :
                   (l.cnt_zero ? tx_word_q[7] : l.out_bit);
  assign miso_oe = !serial_select_n || irq_mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  idle_bus_off_a: assert property (@(posedge clk) disable iff (!nrst)
    cs_s |=> !pdata_oe)
    else $error("data bus driven while not selected");

  // the trailing edge of a write also shows both strobes high; only idle counts here
  noop_bus_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (!cs_s && rd_s && wr_s && state_q == PAR_IDLE) |=>
      !pdata_oe && !cmd_valid && !data_valid)
    else $error("bus driven with both strobes high");

  cmd_port_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (par_emit && hold_p_q == `PORT_CMD) |=>
      cmd_valid && !cmd_from_spi && cmd_code == $past(hold_d_q) && !data_valid)
    else $error("command write not delivered");

  data_port_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (par_emit && hold_p_q == `PORT_DATA) |=>
      data_valid && data_byte == $past(hold_d_q) && !cmd_valid)
    else $error("data write not delivered");

  data_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_act && ps_s == `PORT_DATA) |=> pdata_oe && pdata_out == $past(rd_data))
    else $error("data read drove wrong byte");

  status_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd_act && ps_s == `PORT_CMD) |=> pdata_oe &&
      pdata_out == {$past(int_n_q), 2'b00, $past(busy_q), 4'h0})
    else $error("status byte wrong");

  irq_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    irq_req ##1 irq_req |-> !int_n)
    else $error("pending interrupt not shown low");

  busy_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    spi_evt |=> serial_busy_out [*8] ##68 (!serial_busy_out || spi_evt))
    else $error("busy not held for the byte gap");

  spi_cmd_first_a: assert property (@(posedge clk) disable iff (!nrst)
    spi_cmd |=> cmd_valid && cmd_from_spi && !rd_take)
    else $error("serial command byte not delivered");

  spi_data_take_a: assert property (@(posedge clk) disable iff (!nrst)
    spi_dat |=> data_valid && rd_take)
    else $error("serial data byte not paired with take");

  miso_irq_a: assert property (@(posedge clk) disable iff (!nrst)
    (irq_mode_q && serial_select_n) |-> miso_oe && miso == int_n_q)
    else $error("miso not carrying interrupt");

endmodule

/* File: host_command_port_tb.sv */
// self-checking bench for the host command port, parallel and serial hosts
// assumes the serial host model drives the serial pins on its own timing
`timescale 1ns/100ps
module host_command_port_tb;
  import host_port_pkg::*;
  localparam byte_t IRQ_CMD = 8'h0b; // arbitrary code for the irq mode command
  logic  clk, nrst, parallel_select_n, port_select, rd_n, wr_n, irq_req;
  logic  sck, serial_select_n, mosi, miso, miso_oe, serial_busy_out, int_n, pdata_oe;
  logic  cmd_valid, cmd_from_spi, data_valid, rd_take;
  byte_t pdata_in, pdata_out, cmd_code, data_byte, rd_data, rx, rx2;
  byte_t data_log[$];
  int    mismatches, cmp_count, take_cnt, busy_len, last_len, w, cmd_cnt;

  host_command_port #(.MISO_IRQ_CMD(IRQ_CMD)) host_command_port_i (
    .clk(clk), .nrst(nrst), .parallel_select_n(parallel_select_n),
    .port_select(port_select), .rd_n(rd_n), .wr_n(wr_n), .pdata_in(pdata_in),
    .pdata_out(pdata_out), .pdata_oe(pdata_oe), .sck(sck),
    .serial_select_n(serial_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .serial_busy_out(serial_busy_out), .int_n(int_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_from_spi(cmd_from_spi), .data_valid(data_valid),
    .data_byte(data_byte), .rd_take(rd_take), .rd_data(rd_data), .irq_req(irq_req));
  spi_host_model spi_host_model_i (
    .sck(sck), .serial_select_n(serial_select_n), .mosi(mosi), .miso(miso),
    .serial_busy_out(serial_busy_out));

  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // core side log: data pulses, consumed bytes, length of each busy span
  always @(posedge clk) begin
    if (data_valid === 1'b1) data_log.push_back(data_byte);
    if (rd_take === 1'b1) take_cnt++;
    if (cmd_valid === 1'b1) cmd_cnt++;
    if (serial_busy_out === 1'b1) begin
      busy_len++;
    end else begin
      if (busy_len != 0) last_len = busy_len;
      busy_len = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes held 4 clk so the two-flop synchronisers never miss them
  task automatic pwrite(input logic port, input byte_t d);
    @(negedge clk);
    parallel_select_n = 1'b0;
    port_select = port;
    pdata_in = d;
    wr_n = 1'b0;
    repeat (4) @(negedge clk);
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    parallel_select_n = 1'b1;
    pdata_in = ~d;
    repeat (3) @(negedge clk);
  endtask
  task automatic pread(input logic port, output byte_t d);
    @(negedge clk);
    parallel_select_n = 1'b0;
    port_select = port;
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    d = pdata_out;
    chk({7'h0, pdata_oe}, 8'h01);
    rd_n = 1'b1;
    repeat (4) @(negedge clk);
    parallel_select_n = 1'b1;
    chk({7'h0, pdata_oe}, 8'h00);
    repeat (2) @(negedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // the whole run is about 20 us; the limit leaves wide margin
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    // non-blocking so the serial side sees the reset edge at time zero
    nrst <= 1'b0;
    {parallel_select_n, rd_n, wr_n} = 3'b111;
    {port_select, irq_req} = 2'b00;
    pdata_in = 8'h00;
    rd_data = 8'h5a;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, int_n}, 8'h01);
    pread(1'b1, rx);
    chk(rx, 8'h80);
    $display("test reset_status done");
    // strobes and port select wiggle while deselected, then selected idle
    {port_select, wr_n, rd_n} = 3'b100;
    repeat (6) @(negedge clk);
    chk({7'h0, pdata_oe}, 8'h00);
    {wr_n, rd_n} = 2'b11;
    repeat (4) @(negedge clk);
    parallel_select_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({7'h0, pdata_oe}, 8'h00);
    parallel_select_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(data_log.size(), 8'h00);
    chk(cmd_code, 8'h00);
    $display("test idle_bus done");
    pwrite(1'b1, 8'h12);
    chk(cmd_code, 8'h12);
    chk({7'h0, cmd_from_spi}, 8'h00);
    chk(cmd_cnt, 8'h01);
    pwrite(1'b0, 8'h34);
    chk(data_log.pop_back(), 8'h34);
    pread(1'b0, rx);
    chk(rx, 8'h5a);
    chk(take_cnt, 8'h01);
    irq_req = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, int_n}, 8'h00);
    pread(1'b1, rx);
    chk(rx, 8'h00);
    irq_req = 1'b0;
    $display("test parallel done");
    // r/w-style host: read strobe tied low, select and direction move together
    data_log.delete();
    rd_n = 1'b0;
    @(negedge clk);
    {parallel_select_n, port_select, wr_n} = 3'b000;
    pdata_in = 8'h6e;
    repeat (4) @(negedge clk);
    {parallel_select_n, wr_n} = 2'b11;
    repeat (6) @(negedge clk);
    chk(data_log.size(), 8'h01);
    chk(data_log[0], 8'h6e);
    chk(take_cnt, 8'h01);
    rd_n = 1'b1;
    $display("test rw_strobe done");
    // serial write, status polled in parallel while busy
    data_log.delete();
    spi_host_model_i.sel(1'b0);
    fork
      spi_host_model_i.xfer(8'h12, 8, rx);
      begin
        for (w = 0; w < 40 && serial_busy_out !== 1'b1; w++) @(negedge clk);
        pread(1'b1, rx2);
      end
    join
    // the host may leave before the span logger has seen busy low
    repeat (2) @(negedge clk);
    chk(rx2, 8'h90);
    chk({7'h0, (last_len >= 74 && last_len <= 76)}, 8'h01);
    chk({cmd_from_spi, cmd_code[6:0]}, 8'h92);
    spi_host_model_i.xfer(8'h34, 8, rx);
    spi_host_model_i.xfer(8'h56, 8, rx);
    spi_host_model_i.desel();
    chk(data_log.size(), 8'h02);
    chk(data_log[0], 8'h34);
    chk(data_log[1], 8'h56);
    $display("test serial_write done");
    // serial read: one fresh byte per eight clocks
    @(negedge clk);
    rd_data = 8'h5a;
    spi_host_model_i.sel(1'b0);
    spi_host_model_i.xfer(8'h28, 8, rx);
    spi_host_model_i.xfer(8'hff, 8, rx);
    chk(rx, 8'h5a);
    @(negedge clk);
    rd_data = 8'hc3;
    repeat (80) @(negedge clk);
    spi_host_model_i.xfer(8'hff, 8, rx);
    chk(rx, 8'hc3);
    spi_host_model_i.desel();
    $display("test serial_read done");
    // partial byte dropped, next frame in mode 3 starts at bit 7
    spi_host_model_i.sel(1'b0);
    spi_host_model_i.xfer(8'hf0, 4, rx);
    spi_host_model_i.desel();
    spi_host_model_i.sel(1'b1);
    spi_host_model_i.xfer(8'h27, 8, rx);
    spi_host_model_i.desel();
    chk(cmd_code, 8'h27);
    chk(cmd_cnt, 8'h04);
    $display("test partial_mode3 done");
    // miso turns into the interrupt line while deselected
    spi_host_model_i.sel(1'b0);
    spi_host_model_i.xfer(IRQ_CMD, 8, rx);
    spi_host_model_i.desel();
    repeat (3) @(negedge clk);
    chk({6'h0, miso_oe, miso}, 8'h03);
    irq_req = 1'b1;
    repeat (3) @(negedge clk);
    chk({6'h0, miso_oe, miso}, 8'h02);
    irq_req = 1'b0;
    $display("test irq_mode done");
    end_sim();
  end
endmodule

/* File: host_port_defines.svh */
// constants for the host command port: pin ports, status layout, serial pacing
// assumes a 50 MHz system clock and an sck-driven serial slave beside it
// How it works
// - chip select high: strobes ignored, nothing done, data bus undriven
// - selected with both strobes high: no action, data bus undriven
// - write strobe low, port select high: bus byte becomes a command code
// - write strobe low, port select low: bus byte becomes a data byte
// - read strobe low, write high, port select low: next data byte driven out
// - read at port select high returns status: bit 7 irq low, bit 4 busy
// - completion of certain commands raises an interrupt to the host
// - serial slave works in modes 0 and 3, samples input on rising sck
// - serial output changes on falling sck edges while enabled, except each msb, driven from tx_word while the count is zero
// - serial bytes go msb first, exactly eight bits each
// - first serial byte after select is the command, later bytes are data
// - busy output shows the serial side is still handling the last byte
// - serial write bytes are accepted in order until select goes high
// - serial read supplies one byte per eight clocks until select goes high
// - after the irq mode command, miso carries the interrupt while deselected
// - interrupt output is active low while an interrupt is pending
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define CLK_PERIOD_NS      20
`define BYTE_GAP_TIME_NS   1500
`define BYTE_GAP_CYCLES    ((`BYTE_GAP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CNT_W          7

`define BYTE_BITS          8
`define STAT_IRQ_N_BIT     7
`define STAT_BUSY_BIT      4
`define PORT_CMD           1'b1
`define PORT_DATA          1'b0

`define INT_N_RESET        1'b1
`define BUSY_RESET         1'b0
`define IRQ_MODE_RESET     1'b0
`define MISO_IRQ_CMD_DEF   8'h00

`endif

/* File: host_port_pkg.sv */
// types shared by the host command port files
// assumes the defines header supplies every number
package host_port_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    PAR_IDLE  = 3'b001,
    PAR_WRITE = 3'b010,
    PAR_READ  = 3'b100
  } par_state_t;

endpackage

/* File: spi_host_model.sv */
// host side serial master: drives select, sck and mosi, samples miso
// assumes the bench calls its tasks one at a time; sck 30 ns, unrelated to clk
`timescale 1ns/100ps
module spi_host_model (
  // serial pins
  output logic      sck,
  output logic      serial_select_n,
  output logic      mosi,
  input wire logic  miso,
  input wire logic  serial_busy_out
);
  import host_port_pkg::*;
  localparam int HALF = 15;
  logic idle_lvl;
  initial begin
    // non-blocking so the shifter sees the deselect edge and clears its count
    serial_select_n <= 1'b1;
    sck <= 1'b0;
    mosi <= 1'b0;
    idle_lvl = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // cpol 0 gives mode 0, cpol 1 mode 3; sck stands still outside frames
  task automatic sel(input logic cpol);
    idle_lvl = cpol;
    sck = cpol;
    #HALF;
    serial_select_n = 1'b0;
    #HALF;
  endtask
  task automatic desel();
    #HALF;
    serial_select_n = 1'b1;
    #HALF;
  endtask
  // msb first; a short count leaves a partial byte behind
  task automatic xfer(input byte_t tx, input int nbits, output byte_t rx);
    int w;
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      #HALF;
      rx[i] = miso;
      sck = 1'b1;
      #HALF;
    end
    sck = idle_lvl;
    mosi = ~mosi;
    if (nbits == 8) begin
      // busy rises a few clk late, so polling starts after a margin
      #120;
      w = 0;
      while (serial_busy_out !== 1'b0 && w < 200) begin
        #20;
        w++;
      end
    end
  endtask
endmodule

/* File: spi_link.sv */
// serial shifter clocked by sck, modes 0 and 3
// assumes the host keeps select high between operations; sck may stop then
`timescale 1ns/100ps
`include "host_port_defines.svh"
module spi_link (
  // clocks and resets
  input wire logic   sck,
  input wire logic   nrst,
  // serial pins
  input wire logic   serial_select_n,
  input wire logic   mosi,
  // to core
  spi_link_if.spi    l
);
  import host_port_pkg::*;

  logic [2:0] cnt_q;
  logic       first_q;
  logic [6:0] sh_q;

  ////////////////////////////////////////////////////////////////////////////
  // deselect is the frame's own end, so it clears the count without any sck edge
  always_ff @(posedge sck or posedge serial_select_n) begin
    if (serial_select_n) begin
      cnt_q   <= 3'h0;
      first_q <= 1'b1;
      sh_q    <= 7'h00;
    end else begin
      sh_q  <= {sh_q[5:0], mosi};
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        first_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // finished byte is held for eight more edges; the core picks it up by toggle
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      l.rx_byte <= 8'h00;
      l.rx_cmd  <= 1'b0;
      l.rx_tgl  <= 1'b0;
    end else if (!serial_select_n && cnt_q == 3'h7) begin
      l.rx_byte <= {sh_q, mosi};
      l.rx_cmd  <= first_q;
      l.rx_tgl  <= ~l.rx_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // msb comes from tx_word while the count is zero, later bits change on fall
  always_ff @(negedge sck or posedge serial_select_n) begin
    if (serial_select_n) begin
      l.out_bit <= 1'b0;
    end else begin
      l.out_bit <= l.tx_word[3'h7 - cnt_q];
    end
  end

  assign l.cnt_zero = (cnt_q == 3'h0);

endmodule

/* File: spi_link_if.sv */
// carrier between the system-clock core and the sck-domain serial shifter
// assumes tx_word is held still by the core while a byte is shifted
`timescale 1ns/100ps
interface spi_link_if;
  import host_port_pkg::*;

  byte_t rx_byte;
  logic  rx_cmd;
  logic  rx_tgl;
  byte_t tx_word;
  logic  cnt_zero;
  logic  out_bit;

  modport spi (
    output rx_byte,
    output rx_cmd,
    output rx_tgl,
    output cnt_zero,
    output out_bit,
    input  tx_word
  );

  modport core (
    input  rx_byte,
    input  rx_cmd,
    input  rx_tgl,
    input  cnt_zero,
    input  out_bit,
    output tx_word
  );
endinterface
